// >>> common/rx_ctrl_pkg.sv
/*
  Shared constants and types for the receive queue, framing and self-test
  control block. Assumes a single core clock domain on the consuming side.
*/
package rx_ctrl_pkg;
  localparam int CHAR_W = 12;
  localparam int QUEUE_DEPTH = 8;
  localparam int CLEAR_QUAL_EDGES = 7;
  localparam int FULL_SPACE_LIMIT = 4;
  localparam int BIST_LOOP_LEN = 511;
  localparam int ERR_WINDOW = 28;
  localparam int ERR_LIMIT = 14;
  localparam logic [8:0] BIST_SEED = 9'h1FF;
  localparam logic [1:0] POLICY_ALL = 2'h0;
  localparam logic [1:0] POLICY_LAST = 2'h1;
  // pin sync bank: wordclk,clear_n,oe,cs_n,reframe,bist_n,pol,qsel,policy,width
  localparam int PIN_W = 11;
  localparam logic [10:0] PIN_SYNC_RESET = 11'h2A0;
  localparam int PIN_WCLK = 10;
  localparam int PIN_CLEAR_N = 9;
  localparam int PIN_OE = 8;
  localparam int PIN_CS_N = 7;
  localparam int PIN_REFRAME = 6;
  localparam int PIN_BIST_N = 5;
  localparam int PIN_POL = 4;
  localparam int PIN_QSEL = 3;
  localparam int PIN_POLICY_HI = 2;
  localparam int PIN_POLICY_LO = 1;
  localparam int PIN_WIDTH = 0;

  typedef enum logic [1:0] {
    Q_RUN = 2'b00,
    Q_CLR_IFACE = 2'b01,
    Q_CLR_HOLD = 2'b10
  } queue_state_t;
endpackage

// >>> core/receive_fifo_framing_bist_control.sv
/*
  Receive side control: character framer, sync discard, receive queue with
  its clear sequence and flags, and the receive self-test checker.
  Assumes serial bits arrive on the core clock with a valid strike, at most
  one bit per cycle; all reader pins and straps are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module receive_fifo_framing_bist_control #(
  parameter int DEPTH = rx_ctrl_pkg::QUEUE_DEPTH,
  parameter logic [9:0] SYNC10 = 10'h0FA,
  parameter logic [11:0] SYNC12 = 12'h3F5
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic serialBit,
  input wire logic serialBitValid,
  input wire logic rx_word_clock,
  input wire logic rx_queue_clear_n,
  input wire logic rx_output_enable,
  input wire logic chipSelect_n,
  input wire logic reframe_allow,
  input wire logic selftest_receive_enable_n,
  input wire logic flag_polarity_select,
  input wire logic queue_path_select,
  input wire logic [1:0] sync_discard_policy,
  input wire logic char_width_select,
  output logic [rx_ctrl_pkg::CHAR_W-1:0] rxData,
  output logic rxDataDriveEn,
  output logic code_violation_flag,
  output logic rx_queue_full_flag,
  output logic rx_queue_empty_flag,
  output logic rx_queue_half_flag
);
  localparam int CW = $clog2(DEPTH+1);
  localparam int W = rx_ctrl_pkg::CHAR_W;

  function automatic logic [8:0] lfsrNext(input logic [8:0] s);
    return {s[7:0], s[8] ^ s[4]};
  endfunction

  function automatic logic [4:0] popCount(input logic [27:0] v);
    logic [4:0] n;
    n = '0;
    for (int i = 0; i < 28; i++) begin
      n = n + {4'h0, v[i]};
    end
    return n;
  endfunction

  // two-flop bank for every reader pin and strap
  logic [rx_ctrl_pkg::PIN_W-1:0] pinMeta;
  logic [rx_ctrl_pkg::PIN_W-1:0] pinSync;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta <= rx_ctrl_pkg::PIN_SYNC_RESET;
      pinSync <= rx_ctrl_pkg::PIN_SYNC_RESET;
    end else begin
      pinMeta <= {rx_word_clock, rx_queue_clear_n, rx_output_enable,
                  chipSelect_n, reframe_allow, selftest_receive_enable_n,
                  flag_polarity_select, queue_path_select,
                  sync_discard_policy, char_width_select};
      pinSync <= pinMeta;
    end
  end

  wire clearN = pinSync[rx_ctrl_pkg::PIN_CLEAR_N];
  wire csN = pinSync[rx_ctrl_pkg::PIN_CS_N];
  wire reframeOn = pinSync[rx_ctrl_pkg::PIN_REFRAME];
  wire bistOn = ~pinSync[rx_ctrl_pkg::PIN_BIST_N];
  wire polHigh = pinSync[rx_ctrl_pkg::PIN_POL];
  wire queueOn = pinSync[rx_ctrl_pkg::PIN_QSEL];
  wire [1:0] policy = pinSync[rx_ctrl_pkg::PIN_POLICY_HI:
                              rx_ctrl_pkg::PIN_POLICY_LO];
  wire width10 = pinSync[rx_ctrl_pkg::PIN_WIDTH];
  wire oeActive = polHigh ? pinSync[rx_ctrl_pkg::PIN_OE]
                          : ~pinSync[rx_ctrl_pkg::PIN_OE];

  logic wordClkPrev;
  wire wordRise = pinSync[rx_ctrl_pkg::PIN_WCLK] & ~wordClkPrev;

  // framer
  logic [11:0] shiftReg;
  logic [3:0] bitCnt;
  logic charValid;
  logic [W-1:0] charData;
  wire [11:0] nextShift = {shiftReg[10:0], serialBit};
  wire [3:0] lastBit = width10 ? 4'h9 : 4'hB;
  wire syncSeen = width10 ? (nextShift[9:0] == SYNC10)
                          : (nextShift == SYNC12);
  wire realign = reframeOn & syncSeen;
  wire [W-1:0] framedChar = width10 ? {2'h0, nextShift[9:0]} : nextShift;
  wire [W-1:0] syncPattern = width10 ? {2'h0, SYNC10} : SYNC12;
  wire charIsSync = charData == syncPattern;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shiftReg <= '0;
      bitCnt <= '0;
      charValid <= 1'b0;
      charData <= '0;
      wordClkPrev <= 1'b0;
    end else begin
      wordClkPrev <= pinSync[rx_ctrl_pkg::PIN_WCLK];
      charValid <= 1'b0;
      if (serialBitValid) begin
        shiftReg <= nextShift;
        if (realign || bitCnt == lastBit) begin
          bitCnt <= '0;
          charValid <= 1'b1;
          charData <= framedChar;
        end else begin
          bitCnt <= bitCnt + 1'b1;
        end
      end
    end
  end

  // queue clear qualification and sequence
  rx_ctrl_pkg::queue_state_t qState;
  rx_ctrl_pkg::queue_state_t next_qState;
  logic [2:0] qualCnt;
  wire qualify = queueOn & ~oeActive & ~csN & ~clearN;
  wire qualHit = wordRise & qualify &
                 (qualCnt == 3'(rx_ctrl_pkg::CLEAR_QUAL_EDGES - 1));
  wire clearing = qState != rx_ctrl_pkg::Q_RUN;

  always_comb begin
    next_qState = qState;
    case (qState)
      rx_ctrl_pkg::Q_RUN: begin
        if (qualHit) begin
          next_qState = rx_ctrl_pkg::Q_CLR_IFACE;
        end
      end
      rx_ctrl_pkg::Q_CLR_IFACE: begin
        next_qState = rx_ctrl_pkg::Q_CLR_HOLD;
      end
      rx_ctrl_pkg::Q_CLR_HOLD: begin
        if (clearN || !queueOn) begin
          next_qState = rx_ctrl_pkg::Q_RUN;
        end
      end
      default: next_qState = rx_ctrl_pkg::Q_RUN;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      qState <= rx_ctrl_pkg::Q_RUN;
      qualCnt <= '0;
    end else begin
      qState <= next_qState;
      if (wordRise) begin
        if (!qualify) begin
          qualCnt <= '0;
        end else if (qualCnt != 3'(rx_ctrl_pkg::CLEAR_QUAL_EDGES - 1)) begin
          qualCnt <= qualCnt + 1'b1;
        end
      end
    end
  end

  // sync discard; one char held for the last-of-run policy
  logic holdSync;
  logic holdData;
  logic [W-1:0] holdChar;
  logic wrValid;
  logic [W-1:0] wrData;
  wire takeChar = charValid & ~bistOn;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      holdSync <= 1'b0;
      holdData <= 1'b0;
      holdChar <= '0;
      wrValid <= 1'b0;
      wrData <= '0;
    end else begin
      wrValid <= 1'b0;
      if (holdData) begin
        wrValid <= 1'b1;
        wrData <= holdChar;
        holdData <= 1'b0;
      end else if (takeChar && policy == rx_ctrl_pkg::POLICY_ALL) begin
        wrValid <= 1'b1;
        wrData <= charData;
      end else if (takeChar && policy == rx_ctrl_pkg::POLICY_LAST) begin
        if (charIsSync) begin
          holdSync <= 1'b1;
          holdChar <= charData;
        end else if (holdSync) begin
          wrValid <= 1'b1;
          wrData <= holdChar;
          holdChar <= charData;
          holdSync <= 1'b0;
          holdData <= 1'b1;
        end else begin
          wrValid <= 1'b1;
          wrData <= charData;
        end
      end else if (takeChar) begin
        wrValid <= ~charIsSync;
        wrData <= charData;
      end
    end
  end

  // receive queue
  wire fifoInReady;
  wire fifoOutValid;
  wire [W-1:0] fifoOut;
  wire [CW-1:0] fill;
  wire pushReq = wrValid & queueOn & ~clearing;
  wire readSel = oeActive & ~csN;
  wire pop = wordRise & queueOn & ~clearing & readSel & fifoOutValid;
  wire pushed = pushReq & fifoInReady;

  rx_fifo #(
    .WIDTH(W),
    .DEPTH(DEPTH)
  ) u_queue (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(clearing),
    .inValid(pushReq),
    .inReady(fifoInReady),
    .inData(wrData),
    .outValid(fifoOutValid),
    .outReady(pop),
    .outData(fifoOut),
    .fill(fill)
  );

  // self-test checker
  logic [8:0] lfsr;
  logic [8:0] loopPos;
  logic [27:0] errHist;
  logic bistLost;
  logic loopPulse;
  logic overflowLost;
  wire startSeen = charData == {3'h0, rx_ctrl_pkg::BIST_SEED};
  wire mismatch = charData != {3'h0, lfsr};
  wire lastSym = loopPos == 9'(rx_ctrl_pkg::BIST_LOOP_LEN - 1);
  wire [27:0] nextHist = {errHist[26:0], mismatch};
  wire checkChar = charValid & bistOn & ~startSeen;
  wire violEvent = checkChar & mismatch;
  wire loopEvent = checkChar & lastSym;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr <= rx_ctrl_pkg::BIST_SEED;
      loopPos <= '0;
      errHist <= '0;
      bistLost <= 1'b0;
    end else if (!bistOn) begin
      lfsr <= rx_ctrl_pkg::BIST_SEED;
      loopPos <= '0;
      errHist <= '0;
      bistLost <= 1'b0;
    end else if (charValid && startSeen) begin
      lfsr <= lfsrNext(rx_ctrl_pkg::BIST_SEED);
      loopPos <= 9'h001;
      errHist <= '0;
      bistLost <= 1'b0;
    end else if (checkChar) begin
      lfsr <= lfsrNext(lfsr);
      loopPos <= lastSym ? '0 : loopPos + 1'b1;
      errHist <= nextHist;
      if (popCount(nextHist) >= 5'(rx_ctrl_pkg::ERR_LIMIT)) begin
        bistLost <= 1'b1;
      end
    end
  end

  // flags; events win over the reader-edge clear
  wire [CW-1:0] fullLevel = CW'(DEPTH - rx_ctrl_pkg::FULL_SPACE_LIMIT);
  wire [CW-1:0] halfLevel = CW'(DEPTH / 2);
  wire queueFull = queueOn & ~csN &
                   ((fill >= fullLevel) | overflowLost);
  wire fullActive = bistOn ? (bistLost | loopPulse) : queueFull;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      loopPulse <= 1'b0;
      overflowLost <= 1'b0;
      code_violation_flag <= 1'b0;
      rx_queue_full_flag <= 1'b0;
      rx_queue_empty_flag <= 1'b1;
      rx_queue_half_flag <= 1'b0;
      rxData <= '0;
      rxDataDriveEn <= 1'b0;
    end else begin
      if (loopEvent) begin
        loopPulse <= 1'b1;
      end else if (wordRise) begin
        loopPulse <= 1'b0;
      end
      if (violEvent) begin
        code_violation_flag <= 1'b1;
      end else if (wordRise) begin
        code_violation_flag <= 1'b0;
      end
      if (pushReq && !fifoInReady) begin
        overflowLost <= 1'b1;
      end else if (clearing) begin
        overflowLost <= 1'b0;
      end
      rx_queue_full_flag <= polHigh ? fullActive : ~fullActive;
      rx_queue_empty_flag <= clearing |
                             (~fifoOutValid & ~pushed);
      rx_queue_half_flag <= ~clearing & queueOn & ~csN &
                            (fill >= halfLevel);
      if (qState == rx_ctrl_pkg::Q_CLR_IFACE) begin
        rxData <= '0;
      end else if (pop) begin
        rxData <= fifoOut;
      end else if (!queueOn && wrValid) begin
        rxData <= wrData;
      end
      if (wordRise) begin
        rxDataDriveEn <= readSel;
      end
    end
  end
endmodule
`default_nettype wire

// >>> core/rx_fifo.sv
/*
  Receive character queue with valid/ready on both sides and a fill count.
  Assumes clear and both handshakes come from the core clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module rx_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH+1)-1:0] fill
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  wire push = inValid & inReady;
  wire pop = outValid & outReady;

  function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
    return (p == PW'(DEPTH-1)) ? '0 : p + 1'b1;
  endfunction

  assign inReady = ~clear & (fill != CW'(DEPTH));
  assign outValid = ~clear & (fill != '0);
  assign outData = mem[rdPtr];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      fill <= '0;
    end else if (clear) begin
      wrPtr <= '0;
      rdPtr <= '0;
      fill <= '0;
    end else begin
      if (push) begin
        wrPtr <= nextPtr(wrPtr);
      end
      if (pop) begin
        rdPtr <= nextPtr(rdPtr);
      end
      case ({push, pop})
        2'b10: fill <= fill + 1'b1;
        2'b01: fill <= fill - 1'b1;
        default: fill <= fill;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> testbench/reader_model.sv
/*
  Downstream reader model: reader clock and output enable sense.
  Assumes the bench raises run while it wants reader edges.
*/
`timescale 1ns/1ps
`default_nettype none
module reader_model (
  input wire logic run,
  input wire logic oeActive,
  input wire logic flag_polarity_select,
  output logic rx_word_clock,
  output logic rx_output_enable
);
  // 160 ns period, free phase, stands low between bursts
  initial begin
    rx_word_clock = 1'b0;
    #3;
    forever begin
      #80;
      rx_word_clock = run ? ~rx_word_clock : 1'b0;
    end
  end
  assign rx_output_enable = flag_polarity_select ? oeActive : ~oeActive;
endmodule
`default_nettype wire

// >>> testbench/rx_ctrl_chk.sv
/*
  Port checker for the receive control block, bound to its top module.
  Assumes one core clock domain; reader pins are sampled raw here.
*/
`timescale 1ns/1ps
`default_nettype none
module rx_ctrl_chk (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic serialBitValid,
  input wire logic rx_word_clock,
  input wire logic selftest_receive_enable_n,
  input wire logic flag_polarity_select,
  input wire logic queue_path_select,
  input wire logic chipSelect_n,
  input wire logic rxDataDriveEn,
  input wire logic code_violation_flag,
  input wire logic rx_queue_full_flag,
  input wire logic rx_queue_empty_flag,
  input wire logic rx_queue_half_flag
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic wclkPrev;
  logic [3:0] sinceRise;
  logic [3:0] sinceBit;
  logic csPrev;
  logic [3:0] sinceSel;
  // cycles since the last raw reader rise, serial bit and select change
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wclkPrev <= 1'b0;
      sinceRise <= 4'hF;
      sinceBit <= 4'hF;
      csPrev <= 1'b0;
      sinceSel <= 4'hF;
    end else begin
      wclkPrev <= rx_word_clock;
      csPrev <= chipSelect_n;
      if (chipSelect_n != csPrev) sinceSel <= 4'h0;
      else if (sinceSel != 4'hF) sinceSel <= sinceSel + 4'h1;
      if (rx_word_clock && !wclkPrev) sinceRise <= 4'h0;
      else if (sinceRise != 4'hF) sinceRise <= sinceRise + 4'h1;
      if (serialBitValid) sinceBit <= 4'h0;
      else if (sinceBit != 4'hF) sinceBit <= sinceBit + 4'h1;
    end
  end
  a_empty_not_half: assert property (rx_queue_empty_flag |->
    !rx_queue_half_flag) else $error("half with empty queue");
  a_bypass_full_hi: assert property ((!queue_path_select &&
    selftest_receive_enable_n && flag_polarity_select)[*8] |->
    !rx_queue_full_flag) else $error("full active in bypass");
  a_bypass_full_lo: assert property ((!queue_path_select &&
    selftest_receive_enable_n && !flag_polarity_select)[*8] |->
    rx_queue_full_flag) else $error("full polarity wrong");
  a_drive_at_rise: assert property ($changed(rxDataDriveEn) |->
    sinceRise <= 4'h8) else $error("drive enable away from rise");
  a_viol_one_period: assert property ($fell(code_violation_flag) |->
    sinceRise <= 4'h8) else $error("violation dropped early");
  a_empty_until_write: assert property ($fell(rx_queue_empty_flag) |->
    sinceBit <= 4'h5) else $error("empty fell without write");
  a_empty_at_rise: assert property ($rose(rx_queue_empty_flag) |->
    sinceRise <= 4'h8) else $error("empty rose away from rise");
  a_half_on_write: assert property ($rose(rx_queue_half_flag) |->
    sinceBit <= 4'h5 || sinceSel <= 4'h6)
    else $error("half rose without write");
  c_violation: cover property ($rose(code_violation_flag));
  c_half: cover property ($rose(rx_queue_half_flag));
  c_clear: cover property ($rose(rx_queue_empty_flag));
endmodule
bind receive_fifo_framing_bist_control rx_ctrl_chk i_chk (
  .core_clk(core_clk), .rst_n(rst_n), .serialBitValid(serialBitValid),
  .rx_word_clock(rx_word_clock),
  .selftest_receive_enable_n(selftest_receive_enable_n),
  .flag_polarity_select(flag_polarity_select),
  .queue_path_select(queue_path_select), .chipSelect_n(chipSelect_n),
  .rxDataDriveEn(rxDataDriveEn),
  .code_violation_flag(code_violation_flag),
  .rx_queue_full_flag(rx_queue_full_flag),
  .rx_queue_empty_flag(rx_queue_empty_flag),
  .rx_queue_half_flag(rx_queue_half_flag));
`default_nettype wire

// >>> testbench/tb_receive_fifo_framing_bist_control.sv
/*
  Self-checking bench for the receive control block.
  Assumes the reader model drives clock and output enable.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp, msg) begin total_checks++; \
  if ((got) !== (exp)) begin n_errors++; \
  $display("unexpected at %0t: %s", $time, msg); end end
module tb_receive_fifo_framing_bist_control;
  localparam logic [11:0] SYNC = 12'h3F5;
  logic core_clk, rst_n, sBit, sBitV, wclk, clrN, oeEn, csN, rf, stN;
  logic pol, qsel, width, run, oeAct, driveEn, viol, full, empty, half;
  logic [1:0] policy;
  logic [11:0] rxData;
  int n_errors = 0;
  int total_checks = 0;
  reader_model i_rd (.run(run), .oeActive(oeAct),
    .flag_polarity_select(pol), .rx_word_clock(wclk),
    .rx_output_enable(oeEn));
  receive_fifo_framing_bist_control #(.SYNC12(SYNC)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .serialBit(sBit),
    .serialBitValid(sBitV), .rx_word_clock(wclk),
    .rx_queue_clear_n(clrN), .rx_output_enable(oeEn),
    .chipSelect_n(csN), .reframe_allow(rf),
    .selftest_receive_enable_n(stN), .flag_polarity_select(pol),
    .queue_path_select(qsel), .sync_discard_policy(policy),
    .char_width_select(width), .rxData(rxData), .rxDataDriveEn(driveEn),
    .code_violation_flag(viol), .rx_queue_full_flag(full),
    .rx_queue_empty_flag(empty), .rx_queue_half_flag(half));
  task print_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // one 12-bit character, first bit is the msb
  task send(input logic [11:0] c);
    for (int i = 11; i >= 0; i--) begin
      @(posedge core_clk);
      sBit <= c[i];
      sBitV <= 1'b1;
    end
    @(posedge core_clk);
    sBitV <= 1'b0;
  endtask
  task automatic rises(input int n);
    int k;
    logic prev;
    k = 0;
    prev = wclk;
    run <= 1'b1;
    for (int i = 0; i < 40 * n && k < n; i++) begin
      @(posedge core_clk);
      if (wclk && !prev) k++;
      prev = wclk;
    end
    run <= 1'b0;
    if (k < n) begin
      n_errors++;
      print_verdict();
    end
    cyc(6);
  endtask
  task t_fill_drain();
    for (int i = 0; i < 9; i++) begin
      send(12'(12'h101 + i));
      cyc(4);
      `CHECK(full, i >= 3, "full level")
    end
    `CHECK(half, 1'b1, "half level")
    csN <= 1'b1;
    cyc(6);
    `CHECK(full, 1'b0, "full while deselected")
    csN <= 1'b0;
    oeAct <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rises(1);
      `CHECK(rxData, 12'(12'h101 + i), "read data")
      `CHECK(driveEn, 1'b1, "data drive")
    end
    `CHECK(full, 1'b1, "overflow loss")
    oeAct <= 1'b0;
  endtask
  task t_clear();
    send(12'h0AA);
    clrN <= 1'b0;
    rises(6);
    `CHECK(empty, 1'b0, "early clear")
    clrN <= 1'b1;
    rises(1);
    clrN <= 1'b0;
    rises(6);
    `CHECK(empty, 1'b0, "count kept")
    rises(1);
    `CHECK(empty, 1'b1, "clear empty")
    `CHECK(half, 1'b0, "clear half")
    `CHECK(full, 1'b0, "loss cleared")
    send(12'h0AB);
    cyc(4);
    `CHECK(empty, 1'b1, "stored in clear")
    clrN <= 1'b1;
    cyc(8);
    `CHECK(empty, 1'b1, "empty after clear")
    send(12'h0AC);
    cyc(4);
    `CHECK(empty, 1'b0, "write after clear")
    oeAct <= 1'b1;
    rises(1);
    `CHECK(rxData, 12'h0AC, "clear data")
  endtask
  task t_policy();
    int n;
    for (int p = 0; p < 4; p++) begin
      policy <= 2'(p);
      n = (p == 0) ? 4 : (p == 1) ? 2 : 1;
      cyc(6);
      repeat (3) send(SYNC);
      send(12'h055);
      cyc(4);
      for (int i = 0; i < n; i++) begin
        rises(1);
        `CHECK(rxData, (i == n - 1) ? 12'h055 : SYNC, "policy")
      end
      `CHECK(empty, 1'b1, "policy count")
    end
    policy <= 2'h0;
  endtask
  task t_bypass();
    qsel <= 1'b0;
    cyc(10);
    `CHECK(full, 1'b0, "bypass full")
    pol <= 1'b0;
    cyc(10);
    `CHECK(full, 1'b1, "full low active")
    send(12'h0C3);
    cyc(4);
    `CHECK(rxData, 12'h0C3, "bypass data")
    pol <= 1'b1;
    qsel <= 1'b1;
    cyc(10);
  endtask
  task t_selftest();
    logic [8:0] s;
    stN <= 1'b0;
    cyc(8);
    send(12'h000);
    cyc(4);
    `CHECK(viol, 1'b1, "mismatch")
    rises(1);
    `CHECK(viol, 1'b0, "violation length")
    repeat (13) send(12'h000);
    cyc(4);
    `CHECK(full, 1'b1, "error burst")
    s = 9'h1FF;
    for (int i = 0; i < 511; i++) begin
      if (i == 1 || i == 510) begin
        cyc(3);
        `CHECK(full, 1'b0, "pattern full")
      end
      send({3'h0, s});
      s = {s[7:0], s[8] ^ s[4]};
    end
    cyc(4);
    `CHECK(full, 1'b1, "loop pulse")
    rises(1);
    `CHECK(full, 1'b0, "pulse length")
    `CHECK(viol, 1'b0, "clean pattern")
    stN <= 1'b1;
    cyc(8);
  endtask
  task t_reframe();
    send(12'h000);
    cyc(4);
    rises(1);
    `CHECK(rxData, 12'h000, "flush char")
    width <= 1'b1;
    rf <= 1'b1;
    cyc(6);
    send(12'h0FA);
    cyc(4);
    rises(1);
    `CHECK(rxData, 12'h03E, "ten bit char")
    rises(1);
    `CHECK(rxData, 12'h0FA, "realign on sync")
    rf <= 1'b0;
    cyc(6);
    send(12'h0FA);
    cyc(4);
    rises(1);
    `CHECK(rxData, 12'h03E, "frozen boundary")
    `CHECK(empty, 1'b1, "no realign")
  endtask
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    {rst_n, sBit, sBitV, run, oeAct, csN, rf, width} = 8'h00;
    {clrN, stN, pol, qsel} = 4'hF;
    policy = 2'h0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    cyc(4);
    t_fill_drain();
    t_clear();
    t_policy();
    t_bypass();
    t_selftest();
    t_reframe();
    print_verdict();
  end
endmodule
`default_nettype wire
